// ===== shared/csap_params.svh
// Constants for the codec serial audio port
// What this block does
// - Full-duplex synchronous serial link to an external codec.
// - Transmit and receive paths run with independent timing in asynchronous mode.
// - Each direction has shift clock, frame sync and data lines.
// - Separate clocks and syncs per direction give asynchronous mode.
// - Synchronous mode times both directions from one clock and sync.
// - Word length selectable as 8 or 16 bits, agreed by both partners.
// - Frames hold one to four word slots.
// - Normal mode moves exactly one word per frame.
// - Network mode moves several words per frame, one per slot.
// - Frame sync marks each frame start; slot counting restarts there.
// - Transfer requests: channel 2 for receive data, channel 3 for transmit.
`ifndef CSAP_PARAMS_SVH
`define CSAP_PARAMS_SVH
`define CSAP_REG_CTRL 4'h0
`define CSAP_REG_STAT 4'h4
`define CSAP_REG_RXD 4'h8
`define CSAP_REG_TXD 4'hC
`define CSAP_CTRL_EN 0
`define CSAP_CTRL_SYNC 1
`define CSAP_CTRL_W16 2
`define CSAP_CTRL_NET 3
`define CSAP_CTRL_SLOTS_LO 4
`define CSAP_CTRL_RESET 8'h00
`define CSAP_MAX_SLOTS 4
`define CSAP_FIFO_DEPTH 4
`define CSAP_DMA_RX_CH 2
`define CSAP_DMA_TX_CH 3
`endif

// ===== shared/csap_pkg.sv
// Types for the codec serial audio port
`default_nettype none
package csap_pkg;
  typedef struct packed {
    logic [15:0] sh;
    logic [4:0] bits;
    logic [2:0] slot;
    logic act;
    logic [15:0] word;
    logic done;
  } csap_lane_t;
endpackage
`default_nettype wire

// ===== hw/csap_fifo.sv
// Small valid/ready FIFO in flip-flops
`timescale 1ns/1ns
`default_nettype none
module csap_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 4
) (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic flush_i,
  input wire logic [WIDTH-1:0] in_data_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  output logic [WIDTH-1:0] out_data_o,
  output logic out_valid_o,
  input wire logic out_ready_i
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] rd;
    logic [AW-1:0] wr;
    logic [AW:0] cnt;
  } csap_fifo_st_t;
  csap_fifo_st_t s_q, s_d;
  logic push, pop;
  assign in_ready_o = (s_q.cnt != (AW+1)'(DEPTH));
  assign out_valid_o = (s_q.cnt != '0);
  assign out_data_o = s_q.mem[s_q.rd];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  always_comb begin
    s_d = s_q;
    if (push) begin
      s_d.mem[s_q.wr] = in_data_i;
      s_d.wr = s_q.wr + 1'b1;
    end
    if (pop) begin
      s_d.rd = s_q.rd + 1'b1;
    end
    s_d.cnt = s_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
    if (flush_i) begin
      s_d.rd = '0;
      s_d.wr = '0;
      s_d.cnt = '0;
    end
  end
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule
`default_nettype wire

// ===== hw/csap_lane.sv
// One serial direction: slot counting and shifting on sampled link edges
`timescale 1ns/1ns
`default_nettype none
`include "csap_params.svh"
module csap_lane (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic en_i,
  input wire logic w16_i,
  input wire logic net_i,
  input wire logic [2:0] slots_i,
  input wire logic is_tx_i,
  input wire logic sclk_rise_i,
  input wire logic sclk_fall_i,
  input wire logic fs_i,
  input wire logic sd_i,
  input wire logic [15:0] tx_word_i,
  input wire logic tx_have_i,
  output logic tx_take_o,
  output logic sd_o,
  output logic [15:0] rx_word_o,
  output logic rx_done_o
);
  csap_pkg::csap_lane_t s_q, s_d;
  logic [4:0] wlen;
  logic [2:0] nslots;
  logic last_bit;
  logic mid_take;
  assign wlen = w16_i ? 5'h10 : 5'h08;
  assign nslots = net_i ? slots_i : 3'h1;
  assign last_bit = (s_q.bits == wlen - 5'h01);
  assign sd_o = s_q.sh[15];
  assign rx_word_o = s_q.word;
  assign rx_done_o = s_q.done;
  // Later network slots pop their own word at slot start, else every slot repeats the head
  assign mid_take = is_tx_i && en_i && s_q.act && sclk_rise_i && !fs_i && s_q.bits == 5'h00 &&
    s_q.slot != 3'h0 && tx_have_i;
  assign tx_take_o = (is_tx_i && en_i && sclk_rise_i && fs_i && tx_have_i) || mid_take;
  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    if (!en_i) begin
      s_d.act = 1'b0;
      s_d.slot = 3'h0;
    end else if (sclk_rise_i && fs_i) begin
      // Sync restarts the frame at slot zero
      s_d.act = 1'b1;
      s_d.slot = 3'h0;
      s_d.bits = 5'h00;
      if (is_tx_i) begin
        s_d.sh = tx_have_i ? (w16_i ? tx_word_i : {tx_word_i[7:0], 8'h00}) : 16'h0000;
      end
    end else if (s_q.act) begin
      if (is_tx_i && sclk_rise_i && s_q.bits == 5'h00 && s_q.slot != 3'h0) begin
        // Next network slot word loaded at slot start
        s_d.sh = tx_have_i ? (w16_i ? tx_word_i : {tx_word_i[7:0], 8'h00}) : 16'h0000;
      end
      if (is_tx_i ? sclk_fall_i : sclk_rise_i) begin
        if (!is_tx_i) begin
          s_d.sh = {s_q.sh[14:0], sd_i};
        end else if (!(s_q.bits == 5'h00 && sclk_rise_i)) begin
          s_d.sh = {s_q.sh[14:0], 1'b0};
        end
        if (last_bit) begin
          s_d.bits = 5'h00;
          if (!is_tx_i) begin
            s_d.word = w16_i ? {s_q.sh[14:0], sd_i} : {8'h00, s_q.sh[6:0], sd_i};
            s_d.done = 1'b1;
          end
          s_d.slot = s_q.slot + 3'h1;
          if (s_q.slot + 3'h1 >= nslots) begin
            s_d.act = 1'b0;
          end
        end else begin
          s_d.bits = s_q.bits + 5'h01;
        end
      end
    end
  end
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule
`default_nettype wire

// ===== hw/csap_top.sv
// Codec serial audio port: register port, pin sampling, two lanes and FIFOs
//
// The plain strobed port and the register offsets were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "csap_params.svh"
module csap_top (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic [3:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [15:0] reg_rdata_o,
  input wire logic rx_sclk_i,
  input wire logic rx_fs_i,
  input wire logic rx_sd_i,
  input wire logic tx_sclk_i,
  input wire logic tx_fs_i,
  output logic tx_sd_o,
  output logic dma_rx_req_o,
  output logic dma_tx_req_o
);
  typedef struct packed {
    logic [7:0] ctrl;
    logic [15:0] rdata;
    logic [1:0] rsc, rfs, rsd, tsc, tfs;
    logic rsc_l, tsc_l;
    logic ovr;
    logic tx_sd;
  } csap_top_st_t;
  csap_top_st_t s_q, s_d;
  logic en, sync, w16, net;
  logic [2:0] slots;
  logic r_rise, t_rise, t_fall, r_fs, t_fs, r_sd;
  logic [15:0] rx_word, fifo_rx_data, fifo_tx_data;
  logic rx_done, rx_in_ready, rx_out_valid, rx_pop;
  logic tx_in_ready, tx_out_valid, tx_take, tx_push, lane_sd;
  assign en = s_q.ctrl[`CSAP_CTRL_EN];
  assign sync = s_q.ctrl[`CSAP_CTRL_SYNC];
  assign w16 = s_q.ctrl[`CSAP_CTRL_W16];
  assign net = s_q.ctrl[`CSAP_CTRL_NET];
  // Zero slot count reads as the full four-slot frame
  assign slots = (s_q.ctrl[`CSAP_CTRL_SLOTS_LO+:2] == 2'h0) ? 3'h4 : {1'b0, s_q.ctrl[`CSAP_CTRL_SLOTS_LO+:2]};
  // Sampled edges; synchronous mode uses the receive pair for both
  assign r_rise = s_q.rsc[1] && !s_q.rsc_l;
  assign t_rise = sync ? r_rise : (s_q.tsc[1] && !s_q.tsc_l);
  assign t_fall = sync ? (!s_q.rsc[1] && s_q.rsc_l) : (!s_q.tsc[1] && s_q.tsc_l);
  assign r_fs = s_q.rfs[1];
  assign t_fs = sync ? s_q.rfs[1] : s_q.tfs[1];
  assign r_sd = s_q.rsd[1];
  assign rx_pop = reg_rd_i && reg_addr_i == `CSAP_REG_RXD;
  assign tx_push = reg_wr_i && reg_addr_i == `CSAP_REG_TXD;
  assign reg_rdata_o = s_q.rdata;
  assign tx_sd_o = s_q.tx_sd;
  // Memory transfer requests on channels 2 and 3
  assign dma_rx_req_o = en && rx_out_valid;
  assign dma_tx_req_o = en && tx_in_ready;
  always_comb begin
    s_d = s_q;
    // Two-flop sampling of every link pin
    s_d.rsc = {s_q.rsc[0], rx_sclk_i};
    s_d.rfs = {s_q.rfs[0], rx_fs_i};
    s_d.rsd = {s_q.rsd[0], rx_sd_i};
    s_d.tsc = {s_q.tsc[0], tx_sclk_i};
    s_d.tfs = {s_q.tfs[0], tx_fs_i};
    s_d.rsc_l = s_q.rsc[1];
    s_d.tsc_l = s_q.tsc[1];
    s_d.tx_sd = en && lane_sd;
    if (reg_wr_i && reg_addr_i == `CSAP_REG_CTRL) begin
      s_d.ctrl = reg_wdata_i[7:0];
    end
    // Overrun set wins over a status write clear
    if (reg_wr_i && reg_addr_i == `CSAP_REG_STAT && reg_wdata_i[0]) begin
      s_d.ovr = 1'b0;
    end
    if (rx_done && !rx_in_ready) begin
      s_d.ovr = 1'b1;
    end
    s_d.rdata = 16'h0000;
    if (reg_rd_i) begin
      case (reg_addr_i)
        `CSAP_REG_CTRL: s_d.rdata = {8'h00, s_q.ctrl};
        `CSAP_REG_STAT: s_d.rdata = {12'h000, tx_in_ready, rx_out_valid, en, s_q.ovr};
        `CSAP_REG_RXD: s_d.rdata = rx_out_valid ? fifo_rx_data : 16'h0000;
        default: s_d.rdata = 16'h0000;
      endcase
    end
  end
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  // Full-duplex: separate receive and transmit lanes
  csap_lane u_rx (
    .sys_clk_i(sys_clk_i),
    .nrst_i(nrst_i),
    .en_i(en),
    .w16_i(w16),
    .net_i(net),
    .slots_i(slots),
    .is_tx_i(1'b0),
    .sclk_rise_i(r_rise),
    .sclk_fall_i(1'b0),
    .fs_i(r_fs),
    .sd_i(r_sd),
    .tx_word_i(16'h0000),
    .tx_have_i(1'b0),
    .tx_take_o(),
    .sd_o(),
    .rx_word_o(rx_word),
    .rx_done_o(rx_done)
  );
  csap_lane u_tx (
    .sys_clk_i(sys_clk_i),
    .nrst_i(nrst_i),
    .en_i(en),
    .w16_i(w16),
    .net_i(net),
    .slots_i(slots),
    .is_tx_i(1'b1),
    .sclk_rise_i(t_rise),
    .sclk_fall_i(t_fall),
    .fs_i(t_fs),
    .sd_i(1'b0),
    .tx_word_i(fifo_tx_data),
    .tx_have_i(tx_out_valid),
    .tx_take_o(tx_take),
    .sd_o(lane_sd),
    .rx_word_o(),
    .rx_done_o()
  );
  // A full receive FIFO drops the word and flags overrun
  csap_fifo #(.WIDTH(16), .DEPTH(`CSAP_FIFO_DEPTH)) u_rxf (
    .sys_clk_i(sys_clk_i),
    .nrst_i(nrst_i),
    .flush_i(!en),
    .in_data_i(rx_word),
    .in_valid_i(rx_done),
    .in_ready_o(rx_in_ready),
    .out_data_o(fifo_rx_data),
    .out_valid_o(rx_out_valid),
    .out_ready_i(rx_pop)
  );
  // Empty transmit FIFO sends zeros; software stalls on tx ready
  csap_fifo #(.WIDTH(16), .DEPTH(`CSAP_FIFO_DEPTH)) u_txf (
    .sys_clk_i(sys_clk_i),
    .nrst_i(nrst_i),
    .flush_i(!en),
    .in_data_i(reg_wdata_i),
    .in_valid_i(tx_push),
    .in_ready_o(tx_in_ready),
    .out_data_o(fifo_tx_data),
    .out_valid_o(tx_out_valid),
    .out_ready_i(tx_take)
  );
endmodule
`default_nettype wire

// ===== sim/csap_top_asserts.sv
// Port checker for the codec serial audio port
`timescale 1ns/1ns
`default_nettype none
module csap_top_asserts (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic [3:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [15:0] reg_rdata_o,
  input wire logic tx_sd_o,
  input wire logic dma_rx_req_o,
  input wire logic dma_tx_req_o
);
  logic [5:0] ctrl_q;
  logic [5:0] ctrl_d;
  always_comb begin
    ctrl_d = ctrl_q;
    if (reg_wr_i && reg_addr_i == 4'h0) ctrl_d = reg_wdata_i[5:0];
  end
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) ctrl_q <= 6'h00;
    else ctrl_q <= ctrl_d;
  end
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);
  property p_rd_idle; !$past(reg_rd_i) |-> reg_rdata_o == 16'h0000; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("stray read data");
  property p_ctrl_rb; reg_rd_i && reg_addr_i == 4'h0 |=> reg_rdata_o[5:0] == $past(ctrl_q); endproperty
  a_ctrl_rb: assert property (p_ctrl_rb) else $error("control readback");
  property p_stat; reg_rd_i && reg_addr_i == 4'h4 && ctrl_q[0] |=>
    reg_rdata_o[3:1] == {$past(dma_tx_req_o), $past(dma_rx_req_o), 1'b1}; endproperty
  a_stat: assert property (p_stat) else $error("status levels");
  property p_dis_req; !ctrl_q[0] |-> !dma_rx_req_o && !dma_tx_req_o; endproperty
  a_dis_req: assert property (p_dis_req) else $error("request while off");
  property p_tx_fall; $fell(dma_tx_req_o) && ctrl_q[0] |-> $past(reg_wr_i && reg_addr_i == 4'hC); endproperty
  a_tx_fall: assert property (p_tx_fall) else $error("tx request dropped");
  property p_rx_fall; $fell(dma_rx_req_o) && ctrl_q[0] |-> $past(reg_rd_i && reg_addr_i == 4'h8); endproperty
  a_rx_fall: assert property (p_rx_fall) else $error("rx request dropped");
  property p_tx_on; $rose(ctrl_q[0]) |-> dma_tx_req_o; endproperty
  a_tx_on: assert property (p_tx_on) else $error("no tx request");
  property p_sd_off; !ctrl_q[0] [*3] |-> !tx_sd_o; endproperty
  a_sd_off: assert property (p_sd_off) else $error("data while off");
endmodule
bind csap_top csap_top_asserts chk (.sys_clk_i, .nrst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
  .reg_rdata_o, .tx_sd_o, .dma_rx_req_o, .dma_tx_req_o);
`default_nettype wire

// ===== sim/csap_codec_model.sv
// Behavioural codec: frames, receive words out, transmit words captured
`timescale 1ns/1ns
`default_nettype none
module csap_codec_model (
  output logic rx_sclk_o,
  output logic rx_fs_o,
  output logic rx_sd_o,
  output logic tx_sclk_o,
  output logic tx_fs_o,
  input wire logic tx_sd_i
);
  logic [15:0] rxw [4];
  logic [15:0] txw [4];
  logic shared_q = 1'b0;
  initial begin
    rx_sclk_o = 1'b0;
    rx_fs_o = 1'b0;
    rx_sd_o = 1'b1;
  end
  // Shared mode keeps the transmit pair quiet, so only the common pair can time it
  assign tx_sclk_o = shared_q ? 1'b0 : rx_sclk_o;
  assign tx_fs_o = shared_q ? 1'b0 : rx_fs_o;
  task automatic frame(input int n, input int wl, input logic shared);
    int b;
    shared_q = shared;
    rx_fs_o = 1'b1;
    #80 rx_sclk_o = 1'b1;
    #80 rx_sclk_o = 1'b0;
    rx_fs_o = 1'b0;
    for (b = 0; b < n * wl; b++) begin
      rx_sd_o = rxw[b / wl][wl - 1 - b % wl];
      // Sample mid low phase: the port's output lags the pins by a few of its cycles
      #40 txw[b / wl][wl - 1 - b % wl] = tx_sd_i;
      #40 rx_sclk_o = 1'b1;
      #80 rx_sclk_o = 1'b0;
    end
    // Released line must not keep showing the last bit
    rx_sd_o = ~rx_sd_o;
  endtask
endmodule
`default_nettype wire

// ===== sim/csap_top_bench.sv
// Self-checking bench for the codec serial audio port
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, s) begin checks_done++; if ((e) !== (s)) begin mismatches++; \
  $display("[ERR] %s exp %h got %h", n, e, s); end end
module csap_top_bench;
  logic sys_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic [3:0] reg_addr_i = 4'h0;
  logic [15:0] reg_wdata_i = 16'h0000;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [15:0] reg_rdata_o;
  logic rx_sclk, rx_fs, rx_sd, tx_sclk, tx_fs, tx_sd_o, dma_rx_req_o, dma_tx_req_o;
  int mismatches = 0;
  int checks_done = 0;
  logic [15:0] d;
  logic [15:0] tw [4];
  logic [15:0] cfgs [6] = '{16'h0005, 16'h0001, 16'h000F, 16'h002B, 16'h0039, 16'h001D};
  always #10 sys_clk_i = ~sys_clk_i;
  csap_top dut (.sys_clk_i, .nrst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
    .rx_sclk_i(rx_sclk), .rx_fs_i(rx_fs), .rx_sd_i(rx_sd), .tx_sclk_i(tx_sclk), .tx_fs_i(tx_fs),
    .tx_sd_o, .dma_rx_req_o, .dma_tx_req_o);
  csap_codec_model codec (.rx_sclk_o(rx_sclk), .rx_fs_o(rx_fs), .rx_sd_o(rx_sd), .tx_sclk_o(tx_sclk),
    .tx_fs_o(tx_fs), .tx_sd_i(tx_sd_o));
  function automatic int slots(input logic [15:0] c);
    return (c[5:4] == 2'h0) ? 4 : int'(c[5:4]);
  endfunction
  function automatic logic [15:0] msk(input logic [15:0] c);
    return c[2] ? 16'hFFFF : 16'h00FF;
  endfunction
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge sys_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= v;
    reg_wr_i <= 1'b1;
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] v);
    @(posedge sys_clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b0;
    #1 v = reg_rdata_o;
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic wait_rx();
    int i;
    for (i = 0; i < 300 && dma_rx_req_o !== 1'b1; i++) @(negedge sys_clk_i);
    if (i == 300) begin
      mismatches++;
      stop_test();
    end
  endtask
  initial begin
    int i, n;
    void'($urandom(52182));
    repeat (5) @(posedge sys_clk_i);
    nrst_i <= 1'b1;
    rd(4'h0, d);
    `CHK("ctrl", 16'h0000, d)
    rd(4'h2, d);
    `CHK("unmapped", 16'h0000, d)
    foreach (cfgs[c]) begin
      n = cfgs[c][3] ? slots(cfgs[c]) : 1;
      wr(4'h0, 16'h0000);
      wr(4'h0, cfgs[c]);
      for (i = 0; i < 4; i++) begin
        codec.rxw[i] = 16'($urandom);
        tw[i] = 16'($urandom);
      end
      for (i = 0; i < n; i++) wr(4'hC, tw[i]);
      // Link pins move on falling system clock edges, never on rising ones
      @(negedge sys_clk_i);
      codec.frame(slots(cfgs[c]), cfgs[c][2] ? 16 : 8, cfgs[c][1]);
      for (i = 0; i < n; i++) begin
        wait_rx();
        rd(4'h8, d);
        `CHK("rx", codec.rxw[i] & msk(cfgs[c]), d & msk(cfgs[c]))
        `CHK("tx", tw[i] & msk(cfgs[c]), codec.txw[i] & msk(cfgs[c]))
      end
      repeat (8) @(negedge sys_clk_i);
      `CHK("rx extra", 1'b0, dma_rx_req_o)
    end
    wr(4'h0, 16'h0000);
    wr(4'h0, 16'h0001);
    // Fifth write meets a full buffer and is dropped
    for (i = 0; i < 5; i++) wr(4'hC, 16'(i));
    rd(4'h4, d);
    `CHK("stat full", 16'h0002, d)
    wr(4'h0, 16'h0000);
    wr(4'h0, 16'h0001);
    repeat (5) begin
      @(negedge sys_clk_i);
      codec.frame(1, 8, 1'b0);
    end
    repeat (8) @(negedge sys_clk_i);
    rd(4'h4, d);
    `CHK("stat ovr", 16'h000F, d)
    wr(4'h4, 16'h0001);
    rd(4'h4, d);
    `CHK("stat clr", 16'h000E, d)
    for (i = 0; i < 4; i++) begin
      rd(4'h8, d);
      `CHK("drain", codec.rxw[0] & 16'h00FF, d & 16'h00FF)
    end
    `CHK("empty", 1'b0, dma_rx_req_o)
    stop_test();
  end
endmodule
`default_nettype wire
